// [design/tmroc_pkg.sv]
// constants and types for the one-shot / continuous timer
package tmroc_pkg;
   localparam logic [7:0] TMROC_OFF_CTRL = 8'h00;
   localparam logic [7:0] TMROC_OFF_COUNT = 8'h04;
   localparam logic [7:0] TMROC_OFF_RELOAD = 8'h08;
   localparam logic [7:0] TMROC_OFF_STATUS = 8'h0C;
   localparam logic [7:0] TMROC_OFF_IRQ_EN = 8'h10;
   localparam logic [7:0] TMROC_OFF_IRQ_CLR = 8'h14;
   // control fields
   localparam int TMROC_CTRL_EN = 0;
   localparam int TMROC_CTRL_MODE = 1;
   localparam int TMROC_CTRL_POL = 2;
   localparam int TMROC_CTRL_OUTEN = 3;
   localparam int TMROC_CTRL_PRE_LO = 4;
   localparam int TMROC_CTRL_PRE_W = 3;
   localparam logic [15:0] TMROC_COUNT_RESET = 16'h0001;
   localparam logic [15:0] TMROC_RELOAD_RESET = 16'hFFFF;
   localparam logic [15:0] TMROC_COUNT_AFTER_RELOAD = 16'h0001;
   localparam logic [1:0] TMROC_RESP_OKAY = 2'h0;
   localparam logic [1:0] TMROC_RESP_SLVERR = 2'h2;
   typedef enum logic {TMROC_ONESHOT = 1'b0, TMROC_CONT = 1'b1} tmroc_mode_t;
endpackage

// [design/tmroc_prescaler.sv]
// prescaler: divides the system clock by 2**sel, one-cycle enable pulses
`timescale 1ns/1ps
`default_nettype none
module tmroc_prescaler import tmroc_pkg::*; #(
   parameter int SEL_W = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // control
   input wire logic run,
   input wire logic [SEL_W-1:0] sel,
   // tick out
   output logic tick
);
   localparam int CNT_W = (1 << SEL_W) - 1;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [CNT_W-1:0] mask;
   assign mask = CNT_W'((({{CNT_W{1'b0}}, 1'b1}) << sel) - 1'b1);
   assign tick = run && ((cnt_reg & mask) == mask);
   assign cnt_next = run ? CNT_W'(cnt_reg + 1'b1) : '0;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= tick ? '0 : cnt_next;
      end
   end
endmodule // tmroc_prescaler
`default_nettype wire

// [design/tmroc_timer.sv]
// 16-bit one-shot / continuous timer with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module tmroc_timer import tmroc_pkg::*; #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // timer output pin and interrupt
   output logic timer_out,
   output logic irq
);
   // registers
   logic [6:0] ctrl_reg;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] reload_reg;
   logic status_reg;
   logic irq_en_reg;
   logic pulse_reg;
   logic toggle_reg;
   logic [7:0] awaddr_reg;
   logic aw_held_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic w_held_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   // write channel capture
   logic aw_take;
   logic w_take;
   logic wr_go;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign wr_go = (aw_held_reg || aw_take) && (w_held_reg || w_take);
   assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
   assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
   assign wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   logic wr_ctrl;
   logic wr_count;
   logic wr_reload;
   logic wr_ien;
   logic wr_clr;
   logic wr_known;
   assign wr_ctrl = wr_go && wr_addr == TMROC_OFF_CTRL;
   assign wr_count = wr_go && wr_addr == TMROC_OFF_COUNT;
   assign wr_reload = wr_go && wr_addr == TMROC_OFF_RELOAD;
   assign wr_ien = wr_go && wr_addr == TMROC_OFF_IRQ_EN;
   assign wr_clr = wr_go && wr_addr == TMROC_OFF_IRQ_CLR;
   assign wr_known = wr_ctrl || wr_count || wr_reload || wr_ien || wr_clr || wr_addr == TMROC_OFF_STATUS;

   logic [31:0] ctrl_word;
   logic [31:0] count_word;
   logic [31:0] reload_word;
   logic [31:0] ctrl_merged;
   assign ctrl_word = {25'h0, ctrl_reg};
   assign count_word = {{(32-CNT_W){1'b0}}, count_reg};
   assign reload_word = {{(32-CNT_W){1'b0}}, reload_reg};
   assign ctrl_merged = merge(ctrl_word, wr_data, wr_strb);

   // timer core
   logic enabled;
   tmroc_mode_t mode;
   logic tick;
   logic hit;
   logic reload_ev;
   assign enabled = ctrl_reg[TMROC_CTRL_EN];
   assign mode = tmroc_mode_t'(ctrl_reg[TMROC_CTRL_MODE]);
   assign hit = count_reg == reload_reg;
   // only the prescaled system clock advances the count; no external input exists
   assign reload_ev = enabled && tick && hit;

   tmroc_prescaler #(.SEL_W(TMROC_CTRL_PRE_W)) u_pre (
      .clk(clk),
      .resetn(resetn),
      .run(enabled),
      .sel(ctrl_reg[TMROC_CTRL_PRE_LO +: TMROC_CTRL_PRE_W]),
      .tick(tick)
   );

   logic [6:0] ctrl_next;
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = ctrl_merged[6:0];
      end
      if (reload_ev && mode == TMROC_ONESHOT) begin
         ctrl_next[TMROC_CTRL_EN] = 1'b0;
      end
   end

   logic [CNT_W-1:0] count_next;
   always_comb begin
      count_next = count_reg;
      if (wr_count) begin
         count_next = CNT_W'(merge(count_word, wr_data, wr_strb));
      end else if (reload_ev) begin
         count_next = TMROC_COUNT_AFTER_RELOAD;
      end else if (enabled && tick) begin
         count_next = CNT_W'(count_reg + 1'b1);
      end
   end

   // status: set wins over clear
   logic status_next;
   assign status_next = reload_ev || (status_reg && !(wr_clr && wr_data[0] && wr_strb[0]));
   assign irq = status_reg && irq_en_reg;

   // output pin: polarity xor lasting toggle xor one-cycle pulse
   assign timer_out = ctrl_reg[TMROC_CTRL_OUTEN] && (ctrl_reg[TMROC_CTRL_POL] ^ toggle_reg ^ pulse_reg);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_reg <= '0;
         count_reg <= TMROC_COUNT_RESET;
         reload_reg <= TMROC_RELOAD_RESET;
         status_reg <= 1'b0;
         irq_en_reg <= 1'b0;
         pulse_reg <= 1'b0;
         toggle_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         count_reg <= count_next;
         status_reg <= status_next;
         if (wr_reload) begin
            reload_reg <= CNT_W'(merge(reload_word, wr_data, wr_strb));
         end
         if (wr_ien && wr_strb[0]) begin
            irq_en_reg <= wr_data[0];
         end
         pulse_reg <= reload_ev && mode == TMROC_ONESHOT;
         if (reload_ev && mode == TMROC_CONT) begin
            toggle_reg <= !toggle_reg;
         end
      end
   end

   // axi write side
   always_ff @(posedge clk) begin
      if (!resetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         bvalid_reg <= 1'b0;
         bresp_reg <= TMROC_RESP_OKAY;
      end else begin
         if (wr_go) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_known ? TMROC_RESP_OKAY : TMROC_RESP_SLVERR;
         end else begin
            if (aw_take) begin
               aw_held_reg <= 1'b1;
               awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
               w_held_reg <= 1'b1;
               wdata_reg <= s_axi_wdata;
               wstrb_reg <= s_axi_wstrb;
            end
            if (s_axi_bready) begin
               bvalid_reg <= 1'b0;
            end
         end
      end
   end
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // axi read side
   logic rd_go;
   logic [31:0] rd_word;
   logic rd_known;
   assign s_axi_arready = !rvalid_reg;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign rd_known = s_axi_araddr inside {TMROC_OFF_CTRL, TMROC_OFF_COUNT, TMROC_OFF_RELOAD,
                                          TMROC_OFF_STATUS, TMROC_OFF_IRQ_EN, TMROC_OFF_IRQ_CLR};
   assign rd_word = (s_axi_araddr == TMROC_OFF_CTRL) ? ctrl_word :
                    (s_axi_araddr == TMROC_OFF_COUNT) ? count_word :
                    (s_axi_araddr == TMROC_OFF_RELOAD) ? reload_word :
                    (s_axi_araddr == TMROC_OFF_STATUS) ? {31'h0, status_reg} :
                    (s_axi_araddr == TMROC_OFF_IRQ_EN) ? {31'h0, irq_en_reg} : 32'h0;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= TMROC_RESP_OKAY;
      end else if (rd_go) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_known ? TMROC_RESP_OKAY : TMROC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // assertions
   a_oneshot_pulse: assert property (@(posedge clk) disable iff (!resetn)
      (reload_ev && mode == TMROC_ONESHOT && ctrl_reg[TMROC_CTRL_OUTEN] && !wr_ctrl)
      |=> (timer_out != $past(timer_out)) ##1 (timer_out == $past(timer_out, 2)))
      else $error("one-shot output pulse not one cycle");
   a_idle_hold: assert property (@(posedge clk) disable iff (!resetn)
      (!enabled && !wr_count) |=> count_reg == $past(count_reg))
      else $error("count moved while disabled");
   a_no_ext_clock: assert property (@(posedge clk) disable iff (!resetn)
      (enabled && !tick && !wr_count) |=> count_reg == $past(count_reg))
      else $error("count moved without prescaler tick");
   a_count_step: assert property (@(posedge clk) disable iff (!resetn)
      (enabled && tick && !hit && !wr_count) |=> count_reg == $past(count_reg) + 16'h0001)
      else $error("count did not step by one");
   a_cont_stop: assert property (@(posedge clk) disable iff (!resetn)
      (enabled && tick && !wr_count) |=> count_reg != CNT_W'($past(reload_reg) + 16'h0001) || $past(hit) == 1'b0)
      else $error("count passed the reload value");
   a_cont_reload: assert property (@(posedge clk) disable iff (!resetn)
      (reload_ev && mode == TMROC_CONT && !wr_count && !wr_ctrl)
      |=> count_reg == TMROC_COUNT_AFTER_RELOAD && enabled && status_reg)
      else $error("continuous reload wrong");
   a_cont_toggle: assert property (@(posedge clk) disable iff (!resetn)
      (reload_ev && mode == TMROC_CONT && !wr_ctrl) |=> toggle_reg != $past(toggle_reg))
      else $error("continuous output did not toggle");
   a_oneshot_stop: assert property (@(posedge clk) disable iff (!resetn)
      (reload_ev && mode == TMROC_ONESHOT && !wr_ctrl) |=> !enabled && status_reg)
      else $error("one-shot did not stop");
   a_disabled_quiet: assert property (@(posedge clk) disable iff (!resetn)
      !enabled |=> !pulse_reg && toggle_reg == $past(toggle_reg) && !(status_reg && !$past(status_reg)))
      else $error("reload effect while disabled");
   a_start_gate: assert property (@(posedge clk) disable iff (!resetn)
      (!enabled && !wr_ctrl) |=> !enabled)
      else $error("timer started without a control write");
   a_status_sticky: assert property (@(posedge clk) disable iff (!resetn)
      (status_reg && !wr_clr) |=> status_reg)
      else $error("status dropped without a clear");
   a_irq_sets: assert property (@(posedge clk) disable iff (!resetn)
      (reload_ev && irq_en_reg && !wr_ien) |=> irq)
      else $error("enabled reload gave no interrupt");
   a_oneshot_count: assert property (@(posedge clk) disable iff (!resetn)
      (reload_ev && mode == TMROC_ONESHOT && !wr_count) |=> count_reg == TMROC_COUNT_AFTER_RELOAD)
      else $error("one-shot reload count wrong");
   a_pulse_only: assert property (@(posedge clk) disable iff (!resetn)
      !(reload_ev && mode == TMROC_ONESHOT) |=> !pulse_reg)
      else $error("output pulse without one-shot reload");
   a_toggle_hold: assert property (@(posedge clk) disable iff (!resetn)
      !(reload_ev && mode == TMROC_CONT) |=> toggle_reg == $past(toggle_reg))
      else $error("output level changed without reload");

   // main scenarios
   c_oneshot: cover property (@(posedge clk) disable iff (!resetn) reload_ev && mode == TMROC_ONESHOT);
   c_oneshot_out: cover property (@(posedge clk) disable iff (!resetn)
      pulse_reg && ctrl_reg[TMROC_CTRL_OUTEN]);
   c_status_clear: cover property (@(posedge clk) disable iff (!resetn)
      (status_reg && wr_clr) ##1 !status_reg);
   c_cont_twice: cover property (@(posedge clk) disable iff (!resetn)
      (reload_ev && mode == TMROC_CONT) ##[1:1000] (reload_ev && mode == TMROC_CONT));
   c_irq: cover property (@(posedge clk) disable iff (!resetn) irq);
endmodule // tmroc_timer
`default_nettype wire

// [tb/test_tmroc_timer.sv]
// self-checking bench for the one-shot / continuous timer
`timescale 1ns/1ps
`default_nettype none
module test_tmroc_timer import tmroc_pkg::*;;
   logic clk, resetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, timer_out, irq, lvl;
   int bad_count, samples_checked, t1, t2, n;

   tmroc_timer i_dut (.clk(clk), .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_out(timer_out), .irq(irq));

   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // address and data offered together, each released once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, wd, ah, wh;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd)) begin
         @(negedge clk);
         ah = s_axi_awvalid & s_axi_awready;
         wh = s_axi_wvalid & s_axi_wready;
         @(posedge clk);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
         ad = ad | ah;
         wd = wd | wh;
      end
      do @(negedge clk); while (s_axi_bvalid !== 1'b1);
      chk(s_axi_bresp, er);
      @(posedge clk);
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge clk); while (s_axi_arready !== 1'b1);
      @(posedge clk);
      s_axi_arvalid <= 1'b0;
      do @(negedge clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      chk(s_axi_rresp, er);
      @(posedge clk);
      s_axi_rready <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      axi_rd(a, v, TMROC_RESP_OKAY);
      chk(v, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      axi_wr(a, d, TMROC_RESP_OKAY);
   endtask

   // cycles until the output pin leaves its present level; level taken on entry
   task automatic wait_chg(output int c);
      logic l;
      l = timer_out;
      c = 0;
      do begin
         @(negedge clk);
         c++;
      end while (timer_out === l);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      close_out();
   end

   initial begin
      resetn <= 1'b0;
      s_axi_awaddr <= 8'h00;
      s_axi_araddr <= 8'h00;
      s_axi_wdata <= 32'h0;
      s_axi_wstrb <= 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      rdc(TMROC_OFF_CTRL, 32'h0);
      rdc(TMROC_OFF_COUNT, 32'h1);
      rdc(TMROC_OFF_RELOAD, 32'hFFFF);
      rdc(TMROC_OFF_STATUS, 32'h0);
      rdc(TMROC_OFF_IRQ_EN, 32'h0);
      rdc(TMROC_OFF_IRQ_CLR, 32'h0);
      axi_rd(8'h18, rd, TMROC_RESP_SLVERR);
      chk(rd, 32'h0);
      axi_wr(8'h18, 32'h1, TMROC_RESP_SLVERR);
      // continuous, disabled, output on, prescale 2
      wr(TMROC_OFF_CTRL, 32'h1A);
      wr(TMROC_OFF_COUNT, 32'h3);
      wr(TMROC_OFF_RELOAD, 32'h5);
      wr(TMROC_OFF_IRQ_EN, 32'h1);
      repeat (40) @(posedge clk);
      rdc(TMROC_OFF_COUNT, 32'h3);
      rdc(TMROC_OFF_STATUS, 32'h0);
      chk(irq, 1'b0);
      wr(TMROC_OFF_COUNT, 32'h1);
      wr(TMROC_OFF_CTRL, 32'h1B);
      wait_chg(n);
      chk(timer_out, 1'b1);
      chk(irq, 1'b1);
      wait_chg(n);
      chk(n, 32'd10);
      wait_chg(n);
      chk(n, 32'd10);
      chk(timer_out, 1'b1);
      wr(TMROC_OFF_CTRL, 32'h1A);
      rdc(TMROC_OFF_STATUS, 32'h1);
      // mask, unmask and clear the interrupt
      wr(TMROC_OFF_IRQ_EN, 32'h0);
      chk(irq, 1'b0);
      wr(TMROC_OFF_IRQ_EN, 32'h1);
      chk(irq, 1'b1);
      wr(TMROC_OFF_IRQ_CLR, 32'h1);
      chk(irq, 1'b0);
      rdc(TMROC_OFF_STATUS, 32'h0);
      lvl = timer_out;
      wr(TMROC_OFF_CTRL, 32'h1E);
      chk(timer_out ^ lvl, 32'h1);
      // one-shot runs from two start values
      wr(TMROC_OFF_CTRL, 32'h18);
      wr(TMROC_OFF_COUNT, 32'h2);
      wr(TMROC_OFF_RELOAD, 32'h9);
      wr(TMROC_OFF_CTRL, 32'h19);
      wait_chg(t1);
      wait_chg(n);
      chk(n, 32'd1);
      rdc(TMROC_OFF_CTRL, 32'h18);
      rdc(TMROC_OFF_COUNT, 32'h1);
      rdc(TMROC_OFF_STATUS, 32'h1);
      wr(TMROC_OFF_IRQ_CLR, 32'h1);
      repeat (60) @(posedge clk);
      rdc(TMROC_OFF_STATUS, 32'h0);
      wr(TMROC_OFF_COUNT, 32'h6);
      wr(TMROC_OFF_CTRL, 32'h19);
      wait_chg(t2);
      wait_chg(n);
      chk(n, 32'd1);
      chk(t1 - t2, 32'd8);
      close_out();
   end
endmodule // test_tmroc_timer
`default_nettype wire
